// ==== verilog/pgt_top.sv ====
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "pgt_consts.svh"

module pgt_top (
    input  wire logic        CLOCK_I,                    // 20 MHz clock
    input  wire logic        RST_I,                      // Async reset, high
    input  wire logic        PSEL_I,                     // APB select
    input  wire logic        PENABLE_I,                  // APB enable
    input  wire logic        PWRITE_I,                   // APB direction
    input  wire logic [11:0] PADDR_I,                    // APB byte address
    input  wire logic [31:0] PWDATA_I,                   // APB write data
    input  wire logic [3:0]  PSTRB_I,                    // APB byte strobes
    output logic             PREADY_O,                   // APB ready
    output logic [31:0]      PRDATA_O,                   // APB read data
    output logic             PSLVERR_O,                  // APB error
    input  wire logic        ANALOG_LDO_TWO_I,           // Flag, LDO two
    input  wire logic        LOAD_SWITCH_ONE_I,          // Flag, load switch
    input  wire logic        STEP_DOWN_RAIL_SIX_I,       // Flag, rail six
    input  wire logic        STEP_DOWN_RAIL_FIVE_I,      // Flag, rail five
    input  wire logic        STEP_DOWN_RAIL_FOUR_I,      // Flag, rail four
    input  wire logic        STEP_DOWN_RAIL_THREE_I,     // Flag, rail three
    input  wire logic        STEP_DOWN_RAIL_TWO_I,       // Flag, rail two
    input  wire logic        STEP_DOWN_RAIL_ONE_I,       // Flag, rail one
    input  wire logic        CONTROL_PIN_FIVE_I,         // Pin status
    input  wire logic        CONTROL_PIN_FOUR_I,         // Pin status
    input  wire logic        CONTROL_PIN_TWO_I,          // Pin status
    input  wire logic        CONTROL_PIN_ONE_I,          // Pin status
    input  wire logic        TERMINATION_LDO_I,          // Flag, termination LDO
    input  wire logic        SWITCH_RAIL_TWO_I,          // Flag, rail two
    input  wire logic        SWITCH_RAIL_ONE_I,          // Flag, rail one
    input  wire logic        ANALOG_LDO_THREE_I,         // Flag, LDO three
    output logic             POWER_GOOD_OUTPUT_B_O,      // Tree B result
    output logic             POWER_GOOD_OUTPUT_C_O       // Tree C result
);

    // ****************************************
    // Sources
    // ****************************************
    pgt_pkg::pgt_mask_t reg_src;
    pgt_pkg::pgt_mask_t pin_src;

    always_comb
    begin
        reg_src                     = '0;
        reg_src[`PGT_BIT_LDO_TWO]   = ANALOG_LDO_TWO_I;
        reg_src[`PGT_BIT_LOAD_SW1]  = LOAD_SWITCH_ONE_I;
        reg_src[`PGT_BIT_SD_SIX]    = STEP_DOWN_RAIL_SIX_I;
        reg_src[`PGT_BIT_SD_FIVE]   = STEP_DOWN_RAIL_FIVE_I;
        reg_src[`PGT_BIT_SD_FOUR]   = STEP_DOWN_RAIL_FOUR_I;
        reg_src[`PGT_BIT_SD_THREE]  = STEP_DOWN_RAIL_THREE_I;
        reg_src[`PGT_BIT_SD_TWO]    = STEP_DOWN_RAIL_TWO_I;
        reg_src[`PGT_BIT_SD_ONE]    = STEP_DOWN_RAIL_ONE_I;
    end

    always_comb
    begin
        pin_src                     = '0;
        pin_src[`PGT_BIT_CTL_FIVE]  = CONTROL_PIN_FIVE_I;
        pin_src[`PGT_BIT_CTL_FOUR]  = CONTROL_PIN_FOUR_I;
        pin_src[`PGT_BIT_CTL_TWO]   = CONTROL_PIN_TWO_I;
        pin_src[`PGT_BIT_CTL_ONE]   = CONTROL_PIN_ONE_I;
        pin_src[`PGT_BIT_TERM_LDO]  = TERMINATION_LDO_I;
        pin_src[`PGT_BIT_SW_RAIL2]  = SWITCH_RAIL_TWO_I;
        pin_src[`PGT_BIT_SW_RAIL1]  = SWITCH_RAIL_ONE_I;
        pin_src[`PGT_BIT_LDO_THREE] = ANALOG_LDO_THREE_I;
    end

    // ****************************************
    // Address decode
    // ****************************************
    function automatic pgt_pkg::pgt_sel_e decode(input logic [11:0] addr);
        logic [11:0] idx4;
        idx4 = {addr[11:2], 2'b00};
        decode = pgt_pkg::PGT_SEL_NONE;
        if (addr[1:0] == 2'b00)
        begin
            if (idx4 == {2'b00, `PGT_IDX_B_REG, 2'b00})
                decode = pgt_pkg::PGT_SEL_B_REG;
            else if (idx4 == {2'b00, `PGT_IDX_B_PIN, 2'b00})
                decode = pgt_pkg::PGT_SEL_B_PIN;
            else if (idx4 == {2'b00, `PGT_IDX_C_REG, 2'b00})
                decode = pgt_pkg::PGT_SEL_C_REG;
            else if (idx4 == {2'b00, `PGT_IDX_C_PIN, 2'b00})
                decode = pgt_pkg::PGT_SEL_C_PIN;
            else if (idx4 == {2'b00, `PGT_IDX_STATUS, 2'b00})
                decode = pgt_pkg::PGT_SEL_STATUS;
        end
    endfunction

    pgt_pkg::pgt_sel_e sel;
    logic              setup;
    logic              wr_en;

    assign sel   = decode(PADDR_I);
    assign setup = PSEL_I && !PENABLE_I;
    assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0];
    assign PREADY_O = 1'b1;

    // ****************************************
    // Mask registers
    // ****************************************
    pgt_pkg::pgt_mask_t b_reg_q;
    pgt_pkg::pgt_mask_t b_pin_q;
    pgt_pkg::pgt_mask_t c_reg_q;
    pgt_pkg::pgt_mask_t c_pin_q;

    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            b_reg_q <= `PGT_RST_B_REG;
            b_pin_q <= `PGT_RST_B_PIN;
            c_reg_q <= `PGT_RST_C_REG;
            c_pin_q <= `PGT_RST_C_PIN;
        end
        else if (wr_en)
        begin
            if (sel == pgt_pkg::PGT_SEL_B_REG)
                b_reg_q <= PWDATA_I[7:0];
            if (sel == pgt_pkg::PGT_SEL_B_PIN)
                b_pin_q <= PWDATA_I[7:0];
            if (sel == pgt_pkg::PGT_SEL_C_REG)
                c_reg_q <= PWDATA_I[7:0];
            if (sel == pgt_pkg::PGT_SEL_C_PIN)
                c_pin_q <= PWDATA_I[7:0];
        end
    end

    // ****************************************
    // Read data and error, loaded in setup
    // ****************************************
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        err_q;

    always_comb
    begin
        rdata_d = '0;
        unique case (sel)
            pgt_pkg::PGT_SEL_B_REG:  rdata_d[7:0] = b_reg_q;
            pgt_pkg::PGT_SEL_B_PIN:  rdata_d[7:0] = b_pin_q;
            pgt_pkg::PGT_SEL_C_REG:  rdata_d[7:0] = c_reg_q;
            pgt_pkg::PGT_SEL_C_PIN:  rdata_d[7:0] = c_pin_q;
            pgt_pkg::PGT_SEL_STATUS:
            begin
                rdata_d[`PGT_BIT_STAT_B] = POWER_GOOD_OUTPUT_B_O;
                rdata_d[`PGT_BIT_STAT_C] = POWER_GOOD_OUTPUT_C_O;
            end
            pgt_pkg::PGT_SEL_NONE:   rdata_d = '0;
        endcase
    end

    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
            rdata_q <= '0;
        else if (setup)
            rdata_q <= PWRITE_I ? 32'h0000_0000 : rdata_d;
    end

    // Unmapped, or a write to the read-only status word
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
            err_q <= 1'b0;
        else if (setup)
            err_q <= (sel == pgt_pkg::PGT_SEL_NONE) ||
                     (PWRITE_I && sel == pgt_pkg::PGT_SEL_STATUS);
    end

    assign PRDATA_O  = rdata_q;
    assign PSLVERR_O = err_q && PSEL_I && PENABLE_I;

    // ****************************************
    // Power-good trees
    // ****************************************
    pgt_tree u_tree_b (
        .reg_mask_i (b_reg_q),
        .pin_mask_i (b_pin_q),
        .reg_src_i  (reg_src),
        .pin_src_i  (pin_src),
        .good_o     (POWER_GOOD_OUTPUT_B_O)
    );

    pgt_tree u_tree_c (
        .reg_mask_i (c_reg_q),
        .pin_mask_i (c_pin_q),
        .reg_src_i  (reg_src),
        .pin_src_i  (pin_src),
        .good_o     (POWER_GOOD_OUTPUT_C_O)
    );

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RST_I);

    property p_b_reg_write;
        wr_en && sel == pgt_pkg::PGT_SEL_B_REG |=> b_reg_q == $past(PWDATA_I[7:0]);
    endproperty
    a_b_reg_write: assert property (p_b_reg_write)
        else $error("output B regulator mask not written");

    property p_all_masked_good;
        b_reg_q == 8'hff && b_pin_q == 8'hff |-> POWER_GOOD_OUTPUT_B_O;
    endproperty
    a_all_masked_good: assert property (p_all_masked_good)
        else $error("fully masked tree B not good");

    property p_b_pin_read;
        setup && !PWRITE_I && sel == pgt_pkg::PGT_SEL_B_PIN
            ##1 PSEL_I && PENABLE_I |-> PRDATA_O == {24'h000000, b_pin_q};
    endproperty
    a_b_pin_read: assert property (p_b_pin_read)
        else $error("output B pin mask read wrong");

    property p_pin_included;
        !CONTROL_PIN_FIVE_I && !b_pin_q[`PGT_BIT_CTL_FIVE] |-> !POWER_GOOD_OUTPUT_B_O;
    endproperty
    a_pin_included: assert property (p_pin_included)
        else $error("low control pin five ignored by tree B");

    property p_b_reg_reset;
        $past(RST_I) |-> b_reg_q == `PGT_RST_B_REG;
    endproperty
    a_b_reg_reset: assert property (p_b_reg_reset)
        else $error("output B regulator mask reset wrong");

    property p_b_pin_reset;
        $past(RST_I) |-> b_pin_q == `PGT_RST_B_PIN;
    endproperty
    a_b_pin_reset: assert property (p_b_pin_reset)
        else $error("output B pin mask reset wrong");

    property p_c_reg_reset;
        $past(RST_I) |-> c_reg_q == `PGT_RST_C_REG;
    endproperty
    a_c_reg_reset: assert property (p_c_reg_reset)
        else $error("output C regulator mask reset wrong");

    property p_c_pin_reset;
        $past(RST_I) |-> c_pin_q == `PGT_RST_C_PIN;
    endproperty
    a_c_pin_reset: assert property (p_c_pin_reset)
        else $error("output C pin mask reset wrong");

    property p_c_pin_layout;
        !CONTROL_PIN_FIVE_I && !c_pin_q[`PGT_BIT_CTL_FIVE] |-> !POWER_GOOD_OUTPUT_C_O;
    endproperty
    a_c_pin_layout: assert property (p_c_pin_layout)
        else $error("low control pin five ignored by tree C");

    property p_rail_bad;
        !STEP_DOWN_RAIL_ONE_I && !c_reg_q[`PGT_BIT_SD_ONE] |-> !POWER_GOOD_OUTPUT_C_O;
    endproperty
    a_rail_bad: assert property (p_rail_bad)
        else $error("bad unmasked rail left tree C good");

    property p_good_tracks;
        $stable(b_reg_q) && $stable(b_pin_q) && $stable(reg_src) && $stable(pin_src)
            |-> $stable(POWER_GOOD_OUTPUT_B_O);
    endproperty
    a_good_tracks: assert property (p_good_tracks)
        else $error("tree B changed without a cause");

    property p_unmapped_err;
        setup && sel == pgt_pkg::PGT_SEL_NONE ##1 PSEL_I && PENABLE_I |-> PSLVERR_O;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access not flagged");

    property p_b_pin_write;
        wr_en && sel == pgt_pkg::PGT_SEL_B_PIN |=> b_pin_q == $past(PWDATA_I[7:0]);
    endproperty
    a_b_pin_write: assert property (p_b_pin_write)
        else $error("output B pin mask not written");

    property p_c_reg_write;
        wr_en && sel == pgt_pkg::PGT_SEL_C_REG |=> c_reg_q == $past(PWDATA_I[7:0]);
    endproperty
    a_c_reg_write: assert property (p_c_reg_write)
        else $error("output C regulator mask not written");

    property p_c_pin_write;
        wr_en && sel == pgt_pkg::PGT_SEL_C_PIN |=> c_pin_q == $past(PWDATA_I[7:0]);
    endproperty
    a_c_pin_write: assert property (p_c_pin_write)
        else $error("output C pin mask not written");

    property p_c_reg_read;
        setup && !PWRITE_I && sel == pgt_pkg::PGT_SEL_C_REG
            ##1 PSEL_I && PENABLE_I |-> PRDATA_O == {24'h000000, c_reg_q};
    endproperty
    a_c_reg_read: assert property (p_c_reg_read)
        else $error("output C regulator mask read wrong");

    property p_c_all_masked_good;
        c_reg_q == 8'hff && c_pin_q == 8'hff |-> POWER_GOOD_OUTPUT_C_O;
    endproperty
    a_c_all_masked_good: assert property (p_c_all_masked_good)
        else $error("fully masked tree C not good");

    property p_b_rail_bad;
        !STEP_DOWN_RAIL_SIX_I && !b_reg_q[`PGT_BIT_SD_SIX] |-> !POWER_GOOD_OUTPUT_B_O;
    endproperty
    a_b_rail_bad: assert property (p_b_rail_bad)
        else $error("bad unmasked rail six left tree B good");

    property p_ldo_three_bad;
        !ANALOG_LDO_THREE_I && !c_pin_q[`PGT_BIT_LDO_THREE] |-> !POWER_GOOD_OUTPUT_C_O;
    endproperty
    a_ldo_three_bad: assert property (p_ldo_three_bad)
        else $error("bad unmasked LDO three left tree C good");

    property p_status_write_err;
        setup && PWRITE_I && sel == pgt_pkg::PGT_SEL_STATUS ##1 PSEL_I && PENABLE_I
            |-> PSLVERR_O;
    endproperty
    a_status_write_err: assert property (p_status_write_err)
        else $error("write to status word not flagged");

    property p_mapped_no_err;
        setup && !PWRITE_I && sel != pgt_pkg::PGT_SEL_NONE ##1 PSEL_I && PENABLE_I
            |-> !PSLVERR_O;
    endproperty
    a_mapped_no_err: assert property (p_mapped_no_err)
        else $error("mapped read flagged as error");

    c_write_b_reg: cover property (wr_en && sel == pgt_pkg::PGT_SEL_B_REG);
    c_write_c_pin: cover property (wr_en && sel == pgt_pkg::PGT_SEL_C_PIN);
    c_read_status: cover property (setup && !PWRITE_I && sel == pgt_pkg::PGT_SEL_STATUS);
    c_b_rises: cover property ($rose(POWER_GOOD_OUTPUT_B_O));
    c_c_falls: cover property ($fell(POWER_GOOD_OUTPUT_C_O));

endmodule

// ==== verilog/pgt_consts.svh ====
`ifndef PGT_CONSTS_SVH
`define PGT_CONSTS_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define PGT_IDX_B_REG    8'ha8
`define PGT_IDX_B_PIN    8'ha9
`define PGT_IDX_C_REG    8'haa
`define PGT_IDX_C_PIN    8'hab
`define PGT_IDX_STATUS   8'hb8
`define PGT_ADDR_W       12

// ****************************************
// Reset values
// ****************************************
`define PGT_RST_B_REG    8'hc0
`define PGT_RST_B_PIN    8'h2f
`define PGT_RST_C_REG    8'h00
`define PGT_RST_C_PIN    8'h00

// ****************************************
// Regulator mask field positions
// ****************************************
`define PGT_BIT_LDO_TWO   7
`define PGT_BIT_LOAD_SW1  6
`define PGT_BIT_SD_SIX    5
`define PGT_BIT_SD_FIVE   4
`define PGT_BIT_SD_FOUR   3
`define PGT_BIT_SD_THREE  2
`define PGT_BIT_SD_TWO    1
`define PGT_BIT_SD_ONE    0

// ****************************************
// Pin and rail mask field positions
// ****************************************
`define PGT_BIT_CTL_FIVE  7
`define PGT_BIT_CTL_FOUR  6
`define PGT_BIT_CTL_TWO   5
`define PGT_BIT_CTL_ONE   4
`define PGT_BIT_TERM_LDO  3
`define PGT_BIT_SW_RAIL2  2
`define PGT_BIT_SW_RAIL1  1
`define PGT_BIT_LDO_THREE 0

// ****************************************
// Status register fields
// ****************************************
`define PGT_BIT_STAT_B    0
`define PGT_BIT_STAT_C    1

`endif

// ==== verilog/pgt_pkg.sv ====
package pgt_pkg;

    typedef logic [7:0] pgt_mask_t;

    typedef enum logic [2:0] {
        PGT_SEL_NONE   = 3'h0,
        PGT_SEL_B_REG  = 3'h1,
        PGT_SEL_B_PIN  = 3'h2,
        PGT_SEL_C_REG  = 3'h3,
        PGT_SEL_C_PIN  = 3'h4,
        PGT_SEL_STATUS = 3'h5
    } pgt_sel_e;

endpackage

// ==== verilog/pgt_tree.sv ====
`timescale 1ns/1ps

// ****************************************
// One power-good tree
// ****************************************
module pgt_tree (
    input  wire pgt_pkg::pgt_mask_t reg_mask_i, // Regulator mask
    input  wire pgt_pkg::pgt_mask_t pin_mask_i, // Pin and rail mask
    input  wire pgt_pkg::pgt_mask_t reg_src_i,  // Regulator flags
    input  wire pgt_pkg::pgt_mask_t pin_src_i,  // Pin status and rails
    output logic                    good_o      // Aggregate good
);

    // Set mask bit forces a source to count as good
    assign good_o = &(reg_src_i | reg_mask_i) & &(pin_src_i | pin_mask_i);

endmodule

// ==== tb/pgt_src_model.sv ====
`timescale 1ns/1ps

// ****************************************
// Regulator and control pin sources
// ****************************************
module pgt_src_model (
    input  wire logic       clk_i,      // Core clock
    input  wire logic       rst_i,      // Async reset, high
    input  wire logic [7:0] reg_req_i,  // Wanted regulator states
    input  wire logic [7:0] pin_req_i,  // Wanted pin and rail states
    output logic      [7:0] reg_good_o, // Regulator good flags
    output logic      [7:0] pin_good_o  // Pin status and rail flags
);
    // Rails settle one clock after a request; all down in reset
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            reg_good_o <= 8'h00;
        else
            reg_good_o <= reg_req_i;
    end

    // Pin levels pass through a sync stage, high meaning good
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            pin_good_o <= 8'h00;
        else
            pin_good_o <= pin_req_i;
    end
endmodule

// ==== tb/pgt_top_bench.sv ====
`timescale 1ns/1ps
`include "pgt_consts.svh"

module pgt_top_bench;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [7:0]  reg_req;
    logic [7:0]  pin_req;
    logic [7:0]  rg;
    logic [7:0]  pin_ok;
    logic        good_b;
    logic        good_c;
    logic [7:0]  msk [4];
    logic [11:0] adr [4];
    logic [7:0]  rv  [4];
    logic [31:0] rd;
    logic        err;
    int          num_errors;
    int          n_tests;
    int          cycles;

    pgt_src_model i_src (.clk_i(clk), .rst_i(rst), .reg_req_i(reg_req), .pin_req_i(pin_req),
        .reg_good_o(rg), .pin_good_o(pin_ok));

    pgt_top i_dut (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf),
        .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr),
        .ANALOG_LDO_TWO_I(rg[7]), .LOAD_SWITCH_ONE_I(rg[6]), .STEP_DOWN_RAIL_SIX_I(rg[5]),
        .STEP_DOWN_RAIL_FIVE_I(rg[4]), .STEP_DOWN_RAIL_FOUR_I(rg[3]),
        .STEP_DOWN_RAIL_THREE_I(rg[2]), .STEP_DOWN_RAIL_TWO_I(rg[1]),
        .STEP_DOWN_RAIL_ONE_I(rg[0]), .CONTROL_PIN_FIVE_I(pin_ok[7]),
        .CONTROL_PIN_FOUR_I(pin_ok[6]), .CONTROL_PIN_TWO_I(pin_ok[5]),
        .CONTROL_PIN_ONE_I(pin_ok[4]), .TERMINATION_LDO_I(pin_ok[3]),
        .SWITCH_RAIL_TWO_I(pin_ok[2]), .SWITCH_RAIL_ONE_I(pin_ok[1]),
        .ANALOG_LDO_THREE_I(pin_ok[0]),
        .POWER_GOOD_OUTPUT_B_O(good_b), .POWER_GOOD_OUTPUT_C_O(good_c));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic results;
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        chk("access cycles", 32'h1, 32'(n));
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input int i, input logic [7:0] v);
        apb(1'b1, adr[i], {24'h0, v});
        msk[i] = v;
    endtask

    task automatic set_src(input logic [7:0] r, input logic [7:0] p);
        @(posedge clk);
        reg_req <= r;
        pin_req <= p;
        @(posedge clk);
    endtask

    function automatic logic exp_good(input int o);
        return &(reg_req | msk[2*o]) & &(pin_req | msk[2*o+1]);
    endfunction

    task automatic chk_out;
        @(negedge clk);
        chk("good_b", 32'(exp_good(0)), 32'(good_b));
        chk("good_c", 32'(exp_good(1)), 32'(good_c));
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            results;
        end
    end

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        reg_req = 8'hff;
        pin_req = 8'hff;
        num_errors = 0;
        n_tests = 0;
        cycles = 0;
        adr = '{12'({`PGT_IDX_B_REG, 2'b00}), 12'({`PGT_IDX_B_PIN, 2'b00}),
                12'({`PGT_IDX_C_REG, 2'b00}), 12'({`PGT_IDX_C_PIN, 2'b00})};
        rv = '{8'hc0, 8'h2f, 8'h00, 8'h00};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, adr[i], 32'h0);
            chk("reset mask", {24'h0, rv[i]}, rd);
            msk[i] = rv[i];
        end
        set_src(8'h7f, 8'hdf);
        chk_out;
        for (int i = 0; i < 4; i++)
        begin
            wr(i, 8'h5a ^ 8'(i));
            apb(1'b0, adr[i], 32'h0);
            chk("readback", {24'h0, 8'h5a ^ 8'(i)}, rd);
            wr(i, 8'h00);
        end
        // Drop each source alone, then mask it out of one tree
        for (int o = 0; o < 2; o++)
            for (int r = 0; r < 2; r++)
                for (int b = 0; b < 8; b++)
                begin
                    set_src(r ? 8'hff : ~(8'h01 << b), r ? ~(8'h01 << b) : 8'hff);
                    chk_out;
                    wr(2*o + r, 8'h01 << b);
                    chk_out;
                    wr(2*o + r, 8'h00);
                end
        // Every source down, every mask set, then reset mid-run
        set_src(8'h00, 8'h00);
        for (int i = 0; i < 4; i++)
            wr(i, 8'hff);
        chk_out;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, adr[i], 32'h0);
            chk("mid-run reset mask", {24'h0, rv[i]}, rd);
            chk("mapped error", 32'h0, 32'(err));
            msk[i] = rv[i];
        end
        set_src(8'hff, 8'hef);
        wr(3, 8'h10);
        apb(1'b0, 12'({`PGT_IDX_STATUS, 2'b00}), 32'h0);
        chk("status", {30'h0, exp_good(1), exp_good(0)}, rd);
        apb(1'b1, 12'({`PGT_IDX_STATUS, 2'b00}), 32'h3);
        chk("status write error", 32'h1, 32'(err));
        apb(1'b1, 12'h004, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        results;
    end
endmodule
